// ### hw/mcst_top.sv
// Module control and status timing logic: init, reset filter, power, select, interrupt
`timescale 1ns/1ps

// What this block does
// - Leaves initialisation and becomes functional within 2000 ms of power-on or reset.
// - A reset input low shorter than 2 us is ignored; host holds it longer.
// - Two-wire bus answering is enabled no later than 2000 ms after power-on.
// - Within 2000 ms, clears data-not-ready bit and asserts the interrupt output.
// - Interrupt assertion from data-not-ready clearing signals the module is functional.
// - Low-power input high drops to lower power within 100 us.
// - Interrupt output goes low within 200 ms of any triggering condition.
// - Reading flags clears them; interrupt released within 500 us of that read.
// - Loss-of-signal sets its flag and asserts interrupt within 100 ms.
// - Other conditions set their flag and assert interrupt within 200 ms.
// - Setting a mask bit inhibits that flag's interrupt within 100 ms.
// - Clearing a mask bit restores that flag's interrupt within 100 ms.
// - Bus select asserted enables bus answers within 100 us.
// - Bus select deasserted stops bus answers within 100 us.
// - Power-down bit set enters lower power within 100 ms.
// - Power-down bit cleared returns to full function within 300 ms.
// - Mask and power-down delays count from the end of the write transfer.
module mcst_top
    import mcst_pkg::*;
#(
    parameter longint unsigned INIT_CYCLES = mcst_pkg::INIT_CYC
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               arst_n,
    // Module pins
    input  wire logic               module_reset_in_n,
    input  wire logic               bus_select_in_n,
    input  wire logic               low_power_pin,
    output logic                    irq_out_n,
    // Flag conditions from the monitors, raw levels
    input  wire logic [mcst_pkg::NFLAG-1:0] flag_cond_in,
    // Register side, pulses at end of the bus transfer
    input  wire logic               flag_read_done,
    input  wire logic [mcst_pkg::NFLAG-1:0] mask_wr_data,
    input  wire logic               mask_wr_done,
    input  wire logic               pdown_wr_data,
    input  wire logic               pdown_wr_done,
    // Status and control outputs
    output logic [mcst_pkg::NFLAG-1:0] flag_out,
    output logic                    data_not_ready,
    output logic                    bus_answer_en,
    output logic                    low_power_out,
    output logic                    functional_out
);
    import mcst_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]        rst_s;
        logic [1:0]        sel_s;
        logic [1:0]        lp_s;
        logic [NFLAG-1:0]  c0;
        logic [NFLAG-1:0]  c1;
        logic [SCNT_W-1:0] rst_cnt;
        logic [LCNT_W-1:0] init_cnt;
        mcst_mode_t        mode;
        logic              pdown;
        logic [NFLAG-1:0]  mask;
        logic [NFLAG-1:0]  flags;
        logic              irq_n;
        logic              dnr;
        logic              dnr_irq;
        logic              bus_en;
        logic              lowp;
        logic              func;
    } mcst_state_t;

    mcst_state_t st_q, st_d;

    logic [NFLAG-1:0] cond_s;
    assign cond_s = st_q.c1;

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.rst_s = {st_q.rst_s[0], module_reset_in_n};
        st_d.sel_s = {st_q.sel_s[0], bus_select_in_n};
        st_d.lp_s  = {st_q.lp_s[0], low_power_pin};
        st_d.c0    = flag_cond_in;
        st_d.c1    = st_q.c0;

        // Reset pin filter: short glitches counted but never act
        if (!st_q.rst_s[1]) begin
            if (st_q.rst_cnt < SCNT_W'(RST_MIN_CYC)) begin
                st_d.rst_cnt = st_q.rst_cnt + 1'b1;
            end
        end else begin
            st_d.rst_cnt = '0;
        end

        // Mask and power-down updates take effect on the completion pulse
        if (mask_wr_done) begin
            st_d.mask = mask_wr_data;
        end
        if (pdown_wr_done) begin
            st_d.pdown = pdown_wr_data;
        end

        // Sticky flags: a set in the same cycle as a clear wins
        if (flag_read_done) begin
            st_d.flags   = cond_s;
            st_d.dnr_irq = 1'b0;
        end else begin
            st_d.flags = st_q.flags | cond_s;
        end

        unique case (st_q.mode)
            MCST_INIT: begin
                st_d.dnr = 1'b1;
                if (st_q.init_cnt >= LCNT_W'(INIT_CYCLES - 1)) begin
                    st_d.mode    = st_q.pdown ? MCST_PDOWN : MCST_RUN;
                    st_d.dnr     = 1'b0;
                    st_d.dnr_irq = 1'b1;
                end else begin
                    st_d.init_cnt = st_q.init_cnt + 1'b1;
                end
            end
            MCST_RUN: begin
                if (st_q.pdown) begin
                    st_d.mode = MCST_PDOWN;
                end
            end
            MCST_PDOWN: begin
                if (!st_q.pdown) begin
                    st_d.mode = MCST_RUN;
                end
            end
            // Fourth code of the mode field is unused; fall back to init without clearing init_cnt
            default: begin
                st_d.mode = MCST_INIT;
            end
        endcase

        // Filtered reset restarts initialisation
        if (st_q.rst_cnt >= SCNT_W'(RST_MIN_CYC)) begin
            st_d.mode     = MCST_INIT;
            st_d.init_cnt = '0;
            st_d.dnr      = 1'b1;
            st_d.dnr_irq  = 1'b0;
            st_d.flags    = '0;
        end

        st_d.bus_en = (st_q.mode != MCST_INIT) && !st_q.sel_s[1];
        st_d.lowp   = st_q.lp_s[1] || (st_q.mode == MCST_PDOWN);
        // Interrupt held off until init completes
        st_d.irq_n  = (st_q.mode == MCST_INIT) ||
                      !(st_q.dnr_irq || |(st_q.flags & ~st_q.mask));
        // Registered so the pin never shows a decode glitch
        st_d.func   = (st_d.mode == MCST_RUN);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q          <= '0;
            st_q.rst_s    <= 2'h3;
            st_q.sel_s    <= 2'h3;
            st_q.mode     <= MCST_INIT;
            st_q.mask     <= MASK_RST;
            st_q.irq_n    <= 1'b1;
            st_q.dnr      <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign irq_out_n      = st_q.irq_n;
    assign flag_out       = st_q.flags;
    assign data_not_ready = st_q.dnr;
    assign bus_answer_en  = st_q.bus_en;
    assign low_power_out  = st_q.lowp;
    assign functional_out = st_q.func;

    // ==========================================================
    // Checks
    init_irq_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_INIT) |=> irq_out_n)
        else $error("interrupt asserted during init");
    dnr_irq_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_INIT && st_d.mode != MCST_INIT && st_d.dnr_irq)
        |=> !data_not_ready ##1 !irq_out_n)
        else $error("no interrupt after init done");
    los_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT && flag_cond_in[FLAG_LOS]) |-> ##[1:4] flag_out[FLAG_LOS])
        else $error("loss flag not set");
    irq_on_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT && |(flag_out & ~st_q.mask)) |=> !irq_out_n)
        else $error("interrupt not asserted");
    mask_wr_a: assert property (@(posedge mclk) disable iff (!arst_n)
        mask_wr_done |=> (st_q.mask == $past(mask_wr_data)))
        else $error("mask write lost");
    sel_on_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT && !bus_select_in_n)[*4] |-> bus_answer_en)
        else $error("bus not answering");
    sel_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
        bus_select_in_n[*4] |-> !bus_answer_en)
        else $error("bus still answering");
    lp_on_a: assert property (@(posedge mclk) disable iff (!arst_n)
        low_power_pin[*4] |-> low_power_out)
        else $error("low power not entered");
    pdown_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.pdown && st_q.mode != MCST_INIT) |-> ##[1:3] low_power_out)
        else $error("power-down not entered");
    rst_glitch_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_RUN && module_reset_in_n) |=> st_q.mode != MCST_INIT)
        else $error("reset taken without pulse");

    // ==========================================================
    // Initialisation checks
    mode_legal_a: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q.mode inside {MCST_INIT, MCST_RUN, MCST_PDOWN})
        else $error("mode register holds unused code");

    init_len_a: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q.init_cnt <= LCNT_W'(INIT_CYCLES - 1))
        else $error("init counter ran past its end");

    dnr_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_INIT && st_q.init_cnt < LCNT_W'(INIT_CYCLES - 1))
        |=> data_not_ready)
        else $error("not-ready bit dropped early");

    run_dnr_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT) |-> !data_not_ready)
        else $error("not-ready bit set outside init");

    init_done_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_INIT && st_q.init_cnt >= LCNT_W'(INIT_CYCLES - 1)
            && st_q.rst_cnt < SCNT_W'(RST_MIN_CYC))
        |=> st_q.dnr_irq)
        else $error("init end raised no interrupt cause");

    bus_init_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_INIT) |=> !bus_answer_en)
        else $error("bus answering during init");

    // ==========================================================
    // Reset pin filter checks
    rst_cnt_a: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q.rst_cnt <= SCNT_W'(RST_MIN_CYC))
        else $error("reset filter counter overran");

    rst_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q.rst_s[1] |=> (st_q.rst_cnt == '0))
        else $error("reset filter not cleared by high pin");

    rst_take_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.rst_cnt >= SCNT_W'(RST_MIN_CYC))
        |=> (st_q.mode == MCST_INIT && data_not_ready && flag_out == '0))
        else $error("long reset pulse not taken");

    // ==========================================================
    // Flag and interrupt checks
    flag_sync_a: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q.c1 == $past(st_q.c0))
        else $error("condition synchroniser skipped a stage");

    flag_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.rst_cnt < SCNT_W'(RST_MIN_CYC))
        |=> ((flag_out & $past(cond_s)) == $past(cond_s)))
        else $error("present condition not flagged");

    flag_sticky_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (!flag_read_done && st_q.rst_cnt < SCNT_W'(RST_MIN_CYC))
        |=> ((flag_out & $past(flag_out)) == $past(flag_out)))
        else $error("flag lost without a read");

    read_clr_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (flag_read_done && st_q.rst_cnt < SCNT_W'(RST_MIN_CYC))
        |=> (flag_out == $past(cond_s)))
        else $error("read did not clear flags");

    irq_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT && flag_read_done && cond_s == '0)
        |=> ##1 irq_out_n)
        else $error("interrupt not released after read");

    mask_on_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT && !st_q.dnr_irq && (st_q.flags & ~st_q.mask) == '0)
        |=> irq_out_n)
        else $error("masked flag still interrupts");

    // ==========================================================
    // Power and select checks
    pdown_lp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_PDOWN) |=> low_power_out)
        else $error("power-down mode without low power");

    lp_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (!st_q.lp_s[1] && st_q.mode != MCST_PDOWN) |=> !low_power_out)
        else $error("low power without a cause");

    pdown_enter_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_RUN && st_q.pdown && st_q.rst_cnt < SCNT_W'(RST_MIN_CYC))
        |=> !functional_out)
        else $error("power-down bit did not leave run");

    pdown_exit_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode == MCST_PDOWN && !st_q.pdown && st_q.rst_cnt < SCNT_W'(RST_MIN_CYC))
        |=> functional_out)
        else $error("power-down clear did not resume run");

    func_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
        functional_out == (st_q.mode == MCST_RUN))
        else $error("functional output disagrees with mode");

    sel_sync_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q.mode != MCST_INIT && !st_q.sel_s[1])
        |=> bus_answer_en)
        else $error("synced select did not enable bus");

endmodule : mcst_top

// ### hw/mcst_pkg.sv
// Constants and types for the module control and status timing block
package mcst_pkg;

    // ==========================================================
    // Clock
    localparam int unsigned CLK_PERIOD_PS = 8000;

    // ==========================================================
    // Documented times, in their own units
    localparam int unsigned T_INIT_MS        = 2000;
    localparam int unsigned T_RESET_PULSE_US = 2;
    localparam int unsigned T_LOW_POWER_PIN_US      = 100;
    localparam int unsigned T_IRQ_ON_MS      = 200;
    localparam int unsigned T_IRQ_OFF_US     = 500;
    localparam int unsigned T_LOS_MS         = 100;
    localparam int unsigned T_FLAG_MS        = 200;
    localparam int unsigned T_MASK_MS        = 100;
    localparam int unsigned T_SEL_US         = 100;
    localparam int unsigned T_PDOWN_ON_MS    = 100;
    localparam int unsigned T_PDOWN_OFF_MS   = 300;

    // ==========================================================
    // Cycle counts: least times round up, longest round down
    localparam longint unsigned INIT_CYC =
        (64'(T_INIT_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
    localparam int unsigned RST_MIN_CYC =
        (T_RESET_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned LP_CYC  = (T_LOW_POWER_PIN_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned SEL_CYC = (T_SEL_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned IRQ_OFF_CYC = (T_IRQ_OFF_US * 1000000) / CLK_PERIOD_PS;

    // Counter widths
    localparam int unsigned LCNT_W = 32;
    localparam int unsigned SCNT_W = 16;

    // ==========================================================
    // Flag layout
    localparam int unsigned NFLAG    = 8;
    localparam int unsigned FLAG_LOS = 0;

    // ==========================================================
    // Reset values
    localparam logic [NFLAG-1:0] MASK_RST = 8'h00;

    typedef enum logic [1:0] {
        MCST_INIT,
        MCST_RUN,
        MCST_PDOWN
    } mcst_mode_t;

endpackage : mcst_pkg

// ### dv/mcst_host.sv
// Host board model: sideband pins and end-of-transfer strobes
`timescale 1ns/1ps
module mcst_host (
    // Clock
    input  wire logic mclk,
    // Module pins
    output logic       rst_pin_n,
    output logic       sel_n,
    output logic       lp_pin,
    output logic       scl,
    // Register strobes
    output logic       rd_done,
    output logic [7:0] mask_d,
    output logic       mask_done,
    output logic       pd_d,
    output logic       pd_done
);
    // Serial clock parked high by its pull-up between transfers
    initial begin
        {rst_pin_n, sel_n, lp_pin, scl} = 4'h9;
        {rd_done, mask_d, mask_done, pd_d, pd_done} = '0;
    end
    task automatic pins(input logic r, input logic s, input logic l);
        @(posedge mclk);
        rst_pin_n <= r;
        sel_n     <= s;
        lp_pin    <= l;
    endtask : pins
    // Strobe follows the falling serial edge after the ninth clock pulse
    task automatic xfer(input logic [1:0] k, input logic [7:0] v);
        repeat (9) begin
            #80 scl = 1'b0;
            #80 scl = 1'b1;
        end
        #80 scl = 1'b0;
        @(posedge mclk);
        rd_done   <= (k == 2'h0);
        mask_done <= (k == 2'h1);
        pd_done   <= (k == 2'h2);
        if (k == 2'h1) mask_d <= v;
        if (k == 2'h2) pd_d <= v[0];
        @(posedge mclk);
        {rd_done, mask_done, pd_done} <= 3'h0;
        scl <= 1'b1;
    endtask : xfer
endmodule : mcst_host

// ### dv/tb_mcst_top.sv
// Self-checking bench for the control and status timing block
`timescale 1ns/1ps
`define CHK(n, e, o) begin num_checks++; if ((o) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, o); end end
module tb_mcst_top;
    import mcst_pkg::*;
    localparam int INIT_N = 100;
    typedef struct {int id; logic [7:0] e;} mcst_note_t;
    logic             mclk = 1'b0;
    logic             arst_n = 1'b0;
    logic [NFLAG-1:0] flag_cond_in = '0;
    logic [NFLAG-1:0] flag_out, mask_d;
    logic             irq_out_n, data_not_ready, bus_answer_en, low_power_out;
    logic             functional_out, rst_pin_n, sel_n, lp_pin, scl;
    logic             rd_done, mask_done, pd_d, pd_done;
    logic [15:0]      rnd = 16'h4318;
    logic [7:0]       pat;
    int               error_cnt = 0;
    int               num_checks = 0;
    mcst_note_t       q[$];
    mcst_note_t       cur;
    string            nm[6] = '{"irq", "not_ready", "bus_en", "low_pwr", "func", "flags"};

    always #4 mclk = ~mclk;

    mcst_host host (.mclk(mclk), .rst_pin_n(rst_pin_n), .sel_n(sel_n), .lp_pin(lp_pin),
        .scl(scl), .rd_done(rd_done), .mask_d(mask_d), .mask_done(mask_done),
        .pd_d(pd_d), .pd_done(pd_done));

    mcst_top #(.INIT_CYCLES(INIT_N)) DUT (.mclk(mclk), .arst_n(arst_n),
        .module_reset_in_n(rst_pin_n), .bus_select_in_n(sel_n), .low_power_pin(lp_pin),
        .irq_out_n(irq_out_n), .flag_cond_in(flag_cond_in), .flag_read_done(rd_done),
        .mask_wr_data(mask_d), .mask_wr_done(mask_done), .pdown_wr_data(pd_d),
        .pdown_wr_done(pd_done), .flag_out(flag_out), .data_not_ready(data_not_ready),
        .bus_answer_en(bus_answer_en), .low_power_out(low_power_out),
        .functional_out(functional_out));

    function automatic logic [7:0] obs(input int id);
        case (id)
            0: return {7'h0, irq_out_n};
            1: return {7'h0, data_not_ready};
            2: return {7'h0, bus_answer_en};
            3: return {7'h0, low_power_out};
            4: return {7'h0, functional_out};
            default: return flag_out;
        endcase
    endfunction : obs

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    // Bounded wait, then leave a note for the monitor
    task automatic want(input int id, input logic [7:0] e, input int lim);
        int i;
        i = 0;
        @(negedge mclk);
        while (i < lim && obs(id) !== e) begin
            @(negedge mclk);
            i++;
        end
        q.push_back('{id, e});
    endtask : want

    task automatic pulse(input logic [7:0] p);
        @(posedge mclk);
        flag_cond_in <= p;
        @(posedge mclk);
        flag_cond_in <= 8'h00;
    endtask : pulse

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Values read here are those settled before this edge
    always @(posedge mclk)
        while (q.size() != 0) begin
            cur = q.pop_front();
            `CHK(nm[cur.id], cur.e, obs(cur.id))
        end

    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        want(0, 8'h01, 0);
        want(1, 8'h01, 0);
        want(2, 8'h00, 0);
        want(1, 8'h00, INIT_N + 10);
        want(0, 8'h00, 2);
        want(4, 8'h01, 1);
        want(2, 8'h01, 0);
        host.xfer(2'h0, 8'h00);
        want(0, 8'h01, 4);
        $display("test init done");
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            pat = rnd[7:0] | 8'h01;
            pulse(pat);
            want(5, pat, 6);
            want(0, 8'h00, 2);
            host.xfer(2'h0, 8'h00);
            want(5, 8'h00, 4);
            want(0, 8'h01, 4);
        end
        host.xfer(2'h1, 8'hff);
        pulse(pat);
        want(5, pat, 6);
        repeat (8) @(posedge mclk);
        want(0, 8'h01, 0);
        host.xfer(2'h1, 8'h00);
        want(0, 8'h00, 4);
        host.xfer(2'h0, 8'h00);
        want(0, 8'h01, 4);
        $display("test flags done");
        host.pins(1'b1, 1'b1, 1'b1);
        want(2, 8'h00, 6);
        want(3, 8'h01, 6);
        host.pins(1'b1, 1'b0, 1'b0);
        want(2, 8'h01, 6);
        host.xfer(2'h2, 8'h01);
        want(3, 8'h01, 4);
        want(4, 8'h00, 4);
        host.xfer(2'h2, 8'h00);
        want(4, 8'h01, 4);
        $display("test power done");
        host.pins(1'b0, 1'b0, 1'b0);
        repeat (100) @(posedge mclk);
        host.pins(1'b1, 1'b0, 1'b0);
        repeat (8) @(posedge mclk);
        want(4, 8'h01, 0);
        host.pins(1'b0, 1'b0, 1'b0);
        repeat (270) @(posedge mclk);
        want(1, 8'h01, 0);
        host.pins(1'b1, 1'b0, 1'b0);
        want(1, 8'h00, INIT_N + 20);
        want(0, 8'h00, 2);
        $display("test pin reset done");
        repeat (2) @(posedge mclk);
        summarize();
    end
endmodule : tb_mcst_top
